// [test/reset_pin_model.sv]
/*
 * Model of the supply, clear pin and oscillator around the sequencer.
 * Assumes power_on and press_clear come from the bench, changed after an edge.
 */
`timescale 1ns/10ps
module reset_pin_model
(
    input  wire logic ref_clk,
    input  wire logic power_on,
    input  wire logic press_clear,
    output logic      por_vdd_ok,
    output logic      master_clear_n,
    output logic      osc_level_ok,
    output logic      rc_tick
);
    // Levels follow the bench one cycle late; amplitude lags the supply.
    always_ff @(posedge ref_clk)
    begin
        por_vdd_ok     <= power_on;
        master_clear_n <= ~press_clear;
        osc_level_ok   <= por_vdd_ok;
        rc_tick        <= power_on;  // One tick a cycle keeps the delay short.
    end
endmodule : reset_pin_model

// [test/tb_top.sv]
/*
 * Self-checking bench for the phase generator and reset sequencer.
 * Assumes the pin model above and a 50 MHz ref_clk.
 */
`timescale 1ns/10ps
module tb_top;
    logic        ref_clk = 1'b0, rst = 1'b1, power_on = 1'b0, press_clear = 1'b0;
    logic        brownout_detect = 1'b0, sleep_active = 1'b0, wake_event = 1'b0;
    logic        branch_req = 1'b0, master_clear_n_tied_high = 1'b1, ext_exec_mode = 1'b1;
    logic        watchdog_reset = 1'b0, clrwdt_cmd = 1'b0, sleep_cmd = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0]  reg_addr = 2'h0, osc_mode_select = 2'h3;
    logic [7:0]  reg_wdata = 8'h00, periph_owns_pin = 8'h0f, reg_rdata, pin_is_input, d;
    logic [15:0] prog_word, branch_target, prog_addr, instruction_latch, a0;
    logic        por_vdd_ok, master_clear_n, osc_level_ok, rc_tick, exec_valid;
    logic        phase_one, phase_two, phase_three, phase_four, device_in_reset;
    logic        divided_clock_out_pin, divided_clock_oe_n, operand_read, result_write;
    logic        core_addr_latch, core_output_enable_n, core_write_n, strobe_oe_n;
    logic        addr_latch_strobe, output_enable_strobe_n, write_strobe_n;
    int          bad_count = 0, samples_checked = 0, n;
    // Program memory and core strobes follow the design's own timing.
    assign prog_word            = prog_addr ^ 16'h5a00;
    assign branch_target        = ~prog_addr;
    assign core_addr_latch      = phase_one;
    assign core_output_enable_n = phase_three;
    assign core_write_n         = phase_four;
    always #10 ref_clk = ~ref_clk;
    quad_phase_clock_and_reset_seq i_dut (.*);
    reset_pin_model i_pins (.*);
    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            bad_count++;
    endtask : chk
    task automatic reg_read(input logic [1:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : reg_read
    task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic wait_run(output int cnt);
        cnt = 0;
        @(posedge ref_clk) #1;
        while (device_in_reset !== 1'b0 && cnt < 5000)
        begin
            @(posedge ref_clk) #1;
            cnt++;
        end
        if (cnt >= 5000)
            bad_count++;
    endtask : wait_run
    task automatic in_reset_checks;
        chk(phase_one, 1);
        chk({addr_latch_strobe, output_enable_strobe_n, write_strobe_n, strobe_oe_n}, 4'h6);
    endtask : in_reset_checks
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------------
    // Main sequence: power-up, phases, pipeline, clear, flag commands.
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        reg_read(2'h0, d);
        chk(d, 8'h03);
        chk(pin_is_input, 8'hf0);
        in_reset_checks();
        power_on <= 1'b1;
        wait_run(n);
        chk(n >= 3072 && n < 3100, 1);
        for (int i = 0; i < 8; i++)
        begin
            chk({phase_four, phase_three, phase_two, phase_one}, 4'h1 << (i % 4));
            chk(divided_clock_out_pin, 16'(i % 4 < 2));
            chk(result_write, 16'(i == 7));
            chk(addr_latch_strobe, 16'(i % 4 == 1));
            @(posedge ref_clk) #1;
        end
        chk(divided_clock_oe_n, 1'b0);
        @(posedge ref_clk) osc_mode_select <= 2'h0;
        #1 chk(divided_clock_oe_n, 1'b1);
        @(posedge ref_clk) osc_mode_select <= 2'h2;
        #1 chk(divided_clock_oe_n, 1'b0);
        while (phase_two !== 1'b1) @(posedge ref_clk) #1;
        a0 = prog_addr;
        chk(instruction_latch, (a0 - 16'h1) ^ 16'h5a00);
        chk(operand_read, 1);
        repeat (4) @(posedge ref_clk) #1;
        chk(prog_addr, a0 + 16'h1);
        @(posedge ref_clk) branch_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        branch_req <= 1'b0;
        #1 chk(prog_addr, ~(a0 + 16'h1));
        chk(exec_valid, 1'b0);
        reg_write(2'h1, 8'h5a);
        reg_write(2'h2, 8'ha5);
        @(posedge ref_clk) #1;
        chk(pin_is_input, 8'h50);
        press_clear <= 1'b1;
        repeat (6) @(posedge ref_clk) #1;
        chk(pin_is_input, 8'hf0);
        in_reset_checks();
        reg_read(2'h2, d);
        chk(d, 8'ha5);
        reg_read(2'h0, d);
        chk(d[1:0], 2'h3);
        press_clear <= 1'b0;
        wait_run(n);
        chk(n < 8, 1);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge ref_clk);
            {watchdog_reset, clrwdt_cmd, sleep_cmd} <= 3'h1 << k;
            @(posedge ref_clk);
            {watchdog_reset, clrwdt_cmd, sleep_cmd} <= 3'h0;
            wait_run(n);
            reg_read(2'h0, d);
            chk(d[1:0], k == 0 ? 2'h1 : (k == 1 ? 2'h3 : 2'h2));
        end
        @(posedge ref_clk) brownout_detect <= 1'b1;
        @(posedge ref_clk) brownout_detect <= 1'b0;
        wait_run(n);
        chk(n >= 3072, 1'b1);
        reg_read(2'h0, d);
        chk(d, 8'h07);
        complete_run();
    end
    // Cuts a hang short well after the expected run length.
    initial
    begin
        #200000;
        bad_count++;
        complete_run();
    end
endmodule : tb_top

// [verilog/level_sync.sv]
/*
 * Two flip-flop synchroniser for one level.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps

module level_sync
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    // ------------------------------------------------------------------
    // Two stages; only the second stage reads the first.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_q   <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : level_sync

// [verilog/quad_phase_clock_and_reset_seq.sv]
/*
 * Four-phase instruction clock, fetch/execute pipeline timing and
 * reset sequencing with power-up and start-up delays.
 * Assumes ref_clk is the oscillator input, rc_tick a one-cycle pulse per
 * internal RC oscillator period, and inputs synchronous to ref_clk
 * except master_clear_n, which is synchronised here.
 */
// Design decisions made here: the plain strobed port and the placing of the registers.
// Behaviour
// - Divide the clock by four into four non-overlapping phases.
// - In RC mode drive the clock output pin at clock divided by four.
// - Program counter steps in phase one; fetched word latched in phase four.
// - Fetch overlaps execute, giving one instruction per cycle.
// - Latch enters in phase one; operand read phase two, write phase four.
// - A program counter change flushes the fetched word, costing two cycles.
// - Timeout and powerdown flags set per reset cause for software.
// - One register is untouched by every reset.
// - Reset sets every direction bit, making pins inputs.
// - Peripheral reset ownership may override the input default.
// - Phase generator stays in phase one while held in reset.
// - In reset with external execution: latch strobe low, other strobes high.
// - Supply below trip point holds reset, on rising and falling supply.
// - Power-up delay is 96 ms counted on the internal RC tick.
// - Delay starts at power good if clear tied high, else clear rising.
// - Reset holds while the power-up delay runs.
// - Start-up timer adds 1024 cycles, parallel; also on crystal wake.
// - Start-up counter counts only once the oscillator level is good.
// - Two configuration bits select one of four oscillator modes.
// - In external clock mode the output pin gives clock divided by four.
`timescale 1ns/10ps
`include "quad_seq_regs.svh"

module quad_phase_clock_and_reset_seq
    import quad_seq_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        por_vdd_ok,
    input  wire logic        brownout_detect,
    input  wire logic        watchdog_reset,
    input  wire logic        master_clear_n,
    input  wire logic        master_clear_n_tied_high,
    input  wire logic [1:0]  osc_mode_select,
    input  wire logic        osc_level_ok,
    input  wire logic        rc_tick,
    input  wire logic        sleep_active,
    input  wire logic        sleep_cmd,
    input  wire logic        clrwdt_cmd,
    input  wire logic        wake_event,
    input  wire logic [15:0] prog_word,
    input  wire logic        branch_req,
    input  wire logic [15:0] branch_target,
    input  wire logic [7:0]  periph_owns_pin,
    input  wire logic        ext_exec_mode,
    input  wire logic        core_addr_latch,
    input  wire logic        core_output_enable_n,
    input  wire logic        core_write_n,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             phase_one,
    output logic             phase_two,
    output logic             phase_three,
    output logic             phase_four,
    output logic             divided_clock_out_pin,
    output logic             divided_clock_oe_n,
    output logic [15:0]      prog_addr,
    output logic [15:0]      instruction_latch,
    output logic             exec_valid,
    output logic             operand_read,
    output logic             result_write,
    output logic             device_in_reset,
    output logic [7:0]       pin_is_input,
    output logic             addr_latch_strobe,
    output logic             output_enable_strobe_n,
    output logic             write_strobe_n,
    output logic             strobe_oe_n
);

    // ------------------------------------------------------------------
    // State and storage.
    // ------------------------------------------------------------------
    seq_state_t  state_q, state_d;
    phase_t      phase_q;
    logic [11:0] powerup_delay_timer_cnt_q;
    logic [10:0] ost_cnt_q;
    logic        wake_q;
    logic [15:0] pc_q;
    logic [15:0] fetch_latch_q;
    logic        fetch_valid_q;
    logic        branch_pend_q;
    logic        timeout_flag_q, powerdown_flag_q, por_flag_q, bor_flag_q;
    logic [7:0]  dir_q;
    logic [7:0]  keep_q;
    logic        master_clear_n_sync;

    level_sync u_master_clear_n_sync
    (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (master_clear_n),
        .sync_out (master_clear_n_sync)
    );

    // ------------------------------------------------------------------
    // Decodes.
    // ------------------------------------------------------------------
    osc_mode_t osc_mode;
    wire       power_bad;
    wire       running;
    wire       reset_hold;
    wire       powerup_delay_timer_done;
    wire       ost_done;
    wire       crystal_mode;
    wire       wake_start;
    wire       clk_out_mode;
    wire       wr_status;
    wire       wr_dir;
    wire       wr_keep;

    assign osc_mode     = osc_mode_t'(osc_mode_select);
    assign crystal_mode = (osc_mode == LOW_POWER_CRYSTAL_MODE) ||
                          (osc_mode == CRYSTAL_RESONATOR_MODE);
    assign clk_out_mode = (osc_mode == EXTERNAL_CLOCK_MODE) ||
                          (osc_mode == RESISTOR_CAPACITOR_MODE);
    assign power_bad    = !por_vdd_ok || brownout_detect;
    assign running      = (state_q == ST_RUN);
    assign reset_hold   = !running && !wake_q;
    assign powerup_delay_timer_done    = (powerup_delay_timer_cnt_q == 12'(`POWERUP_DELAY_TIMER_TICKS));
    assign ost_done     = (ost_cnt_q == 11'(`OST_CYCLES));
    assign wake_start   = running && sleep_active && wake_event && crystal_mode;
    assign wr_status    = reg_wr && (reg_addr == `REG_STATUS);
    assign wr_dir       = reg_wr && (reg_addr == `REG_DIR);
    assign wr_keep      = reg_wr && (reg_addr == `REG_KEEP);

    // ------------------------------------------------------------------
    // Reset sequencer next state.
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_POR_HOLD:
            begin
                if (!power_bad)
                    state_d = master_clear_n_tied_high ? ST_TIMING : ST_WAIT_MASTER_CLEAR_N;
            end
            ST_WAIT_MASTER_CLEAR_N:
            begin
                if (master_clear_n_sync)
                    state_d = powerup_delay_timer_done ? ST_RUN : ST_TIMING;
            end
            ST_TIMING:
            begin
                if (powerup_delay_timer_done && ost_done && master_clear_n_sync)
                    state_d = ST_RUN;
            end
            ST_RUN:
            begin
                if (!master_clear_n_sync || watchdog_reset)
                    state_d = ST_WAIT_MASTER_CLEAR_N;
                else if (wake_start)
                    state_d = ST_TIMING;
            end
            default:
                state_d = ST_POR_HOLD;
        endcase
        if (power_bad)
            state_d = ST_POR_HOLD;
    end

    // Sequencer state register; a watchdog or clear reset skips the delays.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state_q <= ST_POR_HOLD;
        else
            state_q <= state_d;
    end

    // Wake marker: start-up timing without the reset side effects.
    always_ff @(posedge ref_clk)
    begin
        if (rst || state_d != ST_TIMING)
            wake_q <= 1'b0;
        else if (wake_start)
            wake_q <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Power-up delay and start-up counters.
    // ------------------------------------------------------------------
    // RC-clocked power-up delay
    always_ff @(posedge ref_clk)
    begin
        if (rst || state_q == ST_POR_HOLD)
            powerup_delay_timer_cnt_q <= 12'h000;
        else if (wake_start)
            powerup_delay_timer_cnt_q <= 12'(`POWERUP_DELAY_TIMER_TICKS);
        else if (state_q == ST_TIMING && rc_tick && !powerup_delay_timer_done)
            powerup_delay_timer_cnt_q <= powerup_delay_timer_cnt_q + 12'h001;
    end

    // start-up count once level is good
    always_ff @(posedge ref_clk)
    begin
        if (rst || state_q == ST_POR_HOLD || wake_start)
            ost_cnt_q <= 11'h000;
        else if (state_q == ST_TIMING && osc_level_ok && !ost_done)
            ost_cnt_q <= ost_cnt_q + 11'h001;
    end

    // ------------------------------------------------------------------
    // Phase generator.
    // ------------------------------------------------------------------
    // rotate, held in phase one
    always_ff @(posedge ref_clk)
    begin
        if (rst || !running)
            phase_q <= PH_ONE;
        else
            phase_q <= phase_t'({phase_q[2:0], phase_q[3]});
    end

    assign phase_one   = phase_q[0];
    assign phase_two   = phase_q[1];
    assign phase_three = phase_q[2];
    assign phase_four  = phase_q[3];

    // Next phase is one or two: the generator is held, or leaves phase four or one.
    wire clk_out_next = (state_d == ST_RUN) && (!running || phase_q[3] || phase_q[0]);

    // quarter-rate clock out, high in phases one and two
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            divided_clock_out_pin <= 1'b0;
        else
            divided_clock_out_pin <= clk_out_next;
    end

    assign divided_clock_oe_n = !clk_out_mode;

    // ------------------------------------------------------------------
    // Fetch and execute pipeline.
    // ------------------------------------------------------------------
    // step or branch in phase one
    always_ff @(posedge ref_clk)
    begin
        if (rst || reset_hold)
            pc_q <= `PC_RESET;
        else if (running && phase_one)
            pc_q <= branch_pend_q ? branch_target : pc_q + 16'h0001;
    end

    // branch seen during execute flushes the fetched word
    always_ff @(posedge ref_clk)
    begin
        if (rst || reset_hold)
            branch_pend_q <= 1'b0;
        else if (running && phase_four)
            branch_pend_q <= branch_req && exec_valid;
        else if (running && phase_one)
            branch_pend_q <= 1'b0;
    end

    // fetched word latched in phase four
    always_ff @(posedge ref_clk)
    begin
        if (rst || reset_hold)
        begin
            fetch_latch_q <= 16'h0000;
            fetch_valid_q <= 1'b0;
        end
        else if (running && phase_four)
        begin
            fetch_latch_q <= prog_word;
            fetch_valid_q <= !(branch_req && exec_valid);
        end
    end

    // instruction enters the latch in phase one
    always_ff @(posedge ref_clk)
    begin
        if (rst || reset_hold)
        begin
            instruction_latch <= 16'h0000;
            exec_valid        <= 1'b0;
        end
        else if (running && phase_one)
        begin
            instruction_latch <= fetch_latch_q;
            exec_valid        <= fetch_valid_q;
        end
    end

    assign prog_addr = pc_q;
    // operand read and result write strobes
    assign operand_read = running && phase_two && exec_valid;
    assign result_write = running && phase_four && exec_valid;
    assign device_in_reset = reset_hold;

    // ------------------------------------------------------------------
    // Reset cause flags.
    // ------------------------------------------------------------------
    wire enter_por   = power_bad && (state_q != ST_POR_HOLD);
    wire wdt_evt     = running && watchdog_reset;
    wire master_clear_n_evt    = running && !master_clear_n_sync;

    // flags per cause; hardware event beats a software write
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            timeout_flag_q   <= 1'b1;
            powerdown_flag_q <= 1'b1;
            por_flag_q       <= 1'b0;
            bor_flag_q       <= 1'b0;
        end
        else if (enter_por)
        begin
            timeout_flag_q   <= 1'b1;
            powerdown_flag_q <= 1'b1;
            por_flag_q       <= por_vdd_ok;
            bor_flag_q       <= 1'b0;
        end
        else
        begin
            if (wr_status)
            begin
                por_flag_q <= reg_wdata[`ST_POR_BIT];
                bor_flag_q <= reg_wdata[`ST_BOR_BIT];
            end
            if (wdt_evt)
            begin
                timeout_flag_q   <= 1'b0;
                powerdown_flag_q <= !sleep_active;
            end
            else if (master_clear_n_evt && sleep_active)
                powerdown_flag_q <= 1'b0;
            else if (clrwdt_cmd)
            begin
                timeout_flag_q   <= 1'b1;
                powerdown_flag_q <= 1'b1;
            end
            else if (sleep_cmd)
            begin
                timeout_flag_q   <= 1'b1;
                powerdown_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin direction and software registers.
    // ------------------------------------------------------------------
    // direction bits forced set in reset
    always_ff @(posedge ref_clk)
    begin
        if (rst || reset_hold)
            dir_q <= `DIR_RESET;
        else if (wr_dir)
            dir_q <= reg_wdata;
    end

    // keeps its value through every reset
    always_ff @(posedge ref_clk)
    begin
        if (wr_keep)
            keep_q <= reg_wdata;
    end

    // peripheral ownership overrides the input default
    assign pin_is_input = dir_q & ~periph_owns_pin;

    wire [7:0] status_word = {4'h0, bor_flag_q, por_flag_q,
                              powerdown_flag_q, timeout_flag_q};
    wire [7:0] read_mux = (reg_addr == `REG_STATUS) ? status_word :
                          (reg_addr == `REG_DIR)    ? dir_q :
                          (reg_addr == `REG_KEEP)   ? keep_q : 8'h00;

    // Read data stands one cycle after the read strobe, else zero.
    always_ff @(posedge ref_clk)
    begin
        if (rst || !reg_rd)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= read_mux;
    end

    // ------------------------------------------------------------------
    // External bus strobes.
    // ------------------------------------------------------------------
    // safe strobe levels in reset
    always_ff @(posedge ref_clk)
    begin
        if (rst || reset_hold)
        begin
            addr_latch_strobe      <= 1'b0;
            output_enable_strobe_n <= 1'b1;
            write_strobe_n         <= 1'b1;
        end
        else
        begin
            addr_latch_strobe      <= core_addr_latch;
            output_enable_strobe_n <= core_output_enable_n;
            write_strobe_n         <= core_write_n;
        end
    end

    assign strobe_oe_n = !ext_exec_mode;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_run_phase_one;
        running && phase_one ##1 running;
    endsequence

    sequence s_branch_exec;
        running && phase_four && branch_req && exec_valid ##1 running [*4];
    endsequence

    AST_PHASE_HELD: assert property (!running |=> phase_q == PH_ONE)
        else $error("phase not held in phase one during reset");

    AST_PHASE_ROTATE: assert property (s_run_phase_one |-> phase_two
                                       ##1 (!running || phase_three))
        else $error("phase sequence broken");

    AST_PC_STEP: assert property (running && phase_one && !branch_pend_q
                                  |=> pc_q == $past(pc_q) + 16'h0001)
        else $error("program counter did not step in phase one");

    AST_FETCH_LATCH: assert property (running && phase_four
                                      |=> fetch_latch_q == $past(prog_word))
        else $error("fetched word not latched in phase four");

    AST_FLUSH: assert property (s_branch_exec |-> !exec_valid
                                && pc_q == $past(branch_target, 3))
        else $error("branch did not flush and redirect");

    AST_DIR_RESET: assert property (reset_hold |=> dir_q == `DIR_RESET)
        else $error("direction bits not set in reset");

    AST_STROBES: assert property (reset_hold |=> !addr_latch_strobe
                                  && output_enable_strobe_n && write_strobe_n)
        else $error("bus strobes wrong during reset");

    AST_POWERUP_DELAY_TIMER_HOLD: assert property (state_q == ST_TIMING && !powerup_delay_timer_done
                                    |=> !running)
        else $error("left reset with power-up delay running");

    AST_OST_HOLD: assert property (state_q == ST_TIMING && !ost_done
                                   |=> !running)
        else $error("left reset before start-up count ended");

    AST_POR_FLAGS: assert property (enter_por |=> timeout_flag_q
                                    && powerdown_flag_q && !bor_flag_q)
        else $error("power-on flags wrong");

endmodule : quad_phase_clock_and_reset_seq

// [verilog/quad_seq_pkg.sv]
/*
 * Types shared by the phase generator and reset sequencer.
 * Assumes nothing of its surroundings.
 */
package quad_seq_pkg;

    // ------------------------------------------------------------------
    // Instruction phases, one-hot.
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_ONE   = 4'b0001,
        PH_TWO   = 4'b0010,
        PH_THREE = 4'b0100,
        PH_FOUR  = 4'b1000
    } phase_t;

    // ------------------------------------------------------------------
    // Reset sequencer states, one-hot.
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_POR_HOLD  = 4'b0001,
        ST_WAIT_MASTER_CLEAR_N = 4'b0010,
        ST_TIMING    = 4'b0100,
        ST_RUN       = 4'b1000
    } seq_state_t;

    // ------------------------------------------------------------------
    // Oscillator modes from the two configuration bits.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LOW_POWER_CRYSTAL_MODE   = 2'b00,
        CRYSTAL_RESONATOR_MODE   = 2'b01,
        EXTERNAL_CLOCK_MODE      = 2'b10,
        RESISTOR_CAPACITOR_MODE  = 2'b11
    } osc_mode_t;

endpackage : quad_seq_pkg

// [verilog/quad_seq_regs.svh]
/*
 * Offsets, field positions, reset values and timing counts of the
 * phase generator and reset sequencer.
 * Assumes it is included by bare name from design files that need it.
 */
`ifndef QUAD_SEQ_REGS_SVH
`define QUAD_SEQ_REGS_SVH

// ------------------------------------------------------------------
// Register offsets on the plain register port.
// ------------------------------------------------------------------
`define REG_STATUS      2'h0
`define REG_DIR         2'h1
`define REG_KEEP        2'h2

// ------------------------------------------------------------------
// Field positions in the status register.
// ------------------------------------------------------------------
`define ST_TIMEOUT_BIT  0
`define ST_PWRDOWN_BIT  1
`define ST_POR_BIT      2
`define ST_BOR_BIT      3

// ------------------------------------------------------------------
// Reset values.
// ------------------------------------------------------------------
`define DIR_RESET       8'hff
`define PC_RESET        16'h0000

// ------------------------------------------------------------------
// Timing: power-up delay on the internal RC tick, start-up on the clock.
// ------------------------------------------------------------------
`define POWERUP_DELAY_TIMER_TIME_MS    96
`define POWERUP_DELAY_TIMER_RC_KHZ     32
`define POWERUP_DELAY_TIMER_TICKS      (`POWERUP_DELAY_TIMER_TIME_MS * `POWERUP_DELAY_TIMER_RC_KHZ)
`define OST_CYCLES      1024

`endif
